/* File: common/vibc_pkg.sv */
// vibc_pkg: constants, types and helpers for the video input and boot block.
// assumes a 100 MHz core clock and a separate pixel clock from the source.
package vibc_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned SLOW_SCK_HZ = 1_420_000;
	localparam int unsigned FAST_SCK_HZ = 30_000_000;
	// half periods round up so the serial clock never runs above nominal
	localparam int unsigned SLOW_HALF_CYC =
		(CLK_HZ + 2 * SLOW_SCK_HZ - 1) / (2 * SLOW_SCK_HZ);
	localparam int unsigned FAST_HALF_CYC =
		(CLK_HZ + 2 * FAST_SCK_HZ - 1) / (2 * FAST_SCK_HZ);
	localparam logic [5:0] SLOW_HALF = 6'(SLOW_HALF_CYC);
	localparam logic [5:0] FAST_HALF = 6'(FAST_HALF_CYC);

	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_RDSR = 8'h05;
	localparam logic [7:0] CMD_FAST_READ = 8'h0b;
	localparam logic [7:0] CMD_FILL = 8'h00;
	localparam int SR_BUSY_BIT = 0;
	localparam int SR_LATCH_BIT = 1;
	// 24 address bits reach the whole 16 MB device
	localparam logic [23:0] BOOT_ADDR = 24'h000000;
	localparam int unsigned PROG_BYTES = 16;
	localparam int unsigned READ_HDR = 5;
	localparam logic [4:0] READ_LAST = 5'(READ_HDR + PROG_BYTES - 1);

	localparam int unsigned INIT_TIME_MS = 2940;
	localparam int unsigned INIT_CYCLES = INIT_TIME_MS * (CLK_HZ / 1000);

	localparam int unsigned RATE_TOL_HZ = 2;
	localparam int unsigned RATE_HZ [6] = '{50, 60, 100, 120, 200, 240};
	// bit i of a mask allows RATE_HZ[i]
	localparam logic [5:0] QHD_RATES = 6'h3f;
	localparam logic [5:0] FHD_RATES = 6'h03;
	localparam logic [5:0] STEREO_RATES = 6'h0c;
	localparam logic [11:0] QHD_W = 12'h3c0;
	localparam logic [11:0] QHD_H = 12'h21c;
	localparam logic [11:0] FHD_W = 12'h780;
	localparam logic [11:0] FHD_H = 12'h438;

	typedef enum logic [2:0] {
		BOOT_IDLE = 3'b000,
		BOOT_WREN = 3'b001,
		BOOT_POLL = 3'b010,
		BOOT_READ = 3'b011,
		BOOT_INIT = 3'b100,
		BOOT_DONE = 3'b101
	} vibc_boot_t;

	typedef enum logic [1:0] {
		RES_NONE = 2'b00,
		RES_QHD = 2'b01,
		RES_FHD = 2'b10
	} vibc_res_t;

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} vibc_rgb_t;

	typedef struct packed {
		vibc_res_t res;
		logic stereo;
	} vibc_frame_t;

	function automatic logic rate_fits(logic [31:0] period,
		logic [5:0] allowed);
		logic ok;
		ok = 1'b0;
		for (int i = 0; i < 6; i++) begin
			if (allowed[i] &&
				period >= CLK_HZ / (RATE_HZ[i] + RATE_TOL_HZ) &&
				period <= CLK_HZ / (RATE_HZ[i] - RATE_TOL_HZ)) begin
				ok = 1'b1;
			end
		end
		return ok;
	endfunction
endpackage

/* File: hdl/vibc_sync3.sv */
// vibc_sync3: three-stage synchroniser for one level from another domain.
// assumes the level is slow against the receiving clock.
`timescale 1ns/1ps
module vibc_sync3
	import vibc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic d,
	output logic q
);
	logic s1;
	logic s2;
	logic s3;

	// only the second stage reads the first; q follows once stages agree
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			q <= 1'b0;
		end else if (ce) begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				q <= s3;
			end
		end
	end
endmodule

/* File: hdl/vibc_spi_byte.sv */
// vibc_spi_byte: moves one byte over a mode 0 serial flash link.
// assumes the caller holds chip select and keeps half stable per byte.
`timescale 1ns/1ps
module vibc_spi_byte
	import vibc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic start,
	input wire logic [5:0] half,
	input wire logic [7:0] tx,
	input wire logic miso,
	output logic [7:0] rx,
	output logic busy,
	output logic done,
	output logic sclk,
	output logic mosi
);
	logic [5:0] cnt;
	logic [7:0] sh;
	logic [2:0] bitn;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 6'h00;
			sh <= 8'h00;
			bitn <= 3'h0;
			rx <= 8'h00;
			busy <= 1'b0;
			done <= 1'b0;
			sclk <= 1'b0;
			mosi <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (start && !busy) begin
				busy <= 1'b1;
				sh <= tx;
				mosi <= tx[7];
				cnt <= 6'h00;
				bitn <= 3'h0;
			end else if (busy) begin
				if (cnt == half - 6'h01) begin
					cnt <= 6'h00;
					if (!sclk) begin
						sclk <= 1'b1;
					end else begin
						// capture late too: tolerates slow clock-to-output
						sclk <= 1'b0;
						rx <= {rx[6:0], miso};
						sh <= {sh[6:0], 1'b0};
						mosi <= sh[6];
						if (bitn == 3'h7) begin
							busy <= 1'b0;
							done <= 1'b1;
						end else begin
							bitn <= bitn + 3'h1;
						end
					end
				end else begin
					cnt <= cnt + 6'h01;
				end
			end
		end
	end

	sclk_idle_a: assert property (
		@(posedge clk) disable iff (!resetn) !busy |-> !sclk)
		else $error("serial clock not low while idle");

	fall_sample_a: assert property (
		@(posedge clk) disable iff (!resetn)
		$fell(sclk) |-> rx == {$past(rx[6:0]), $past(miso)})
		else $error("input bit not taken on falling clock edge");
endmodule

/* File: hdl/vibc_top.sv */
// vibc_top: boot sequencing, init-done line and parallel video front end.
// assumes a pull-up on the init-done line and a source on its own pixel clock.
`timescale 1ns/1ps
module vibc_top
	import vibc_pkg::*;
#(
	parameter logic [31:0] INIT_CYCLES_P = 32'(INIT_CYCLES)
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic pix_clk,
	input wire logic stereo_mode,
	input wire vibc_rgb_t parallel_pixel_bus,
	input wire logic vid_vsync,
	input wire logic vid_de,
	input wire logic eye_select_in,
	input wire logic flash_miso,
	input wire logic [3:0] prog_rd_addr,
	output logic flash_sclk,
	output logic flash_mosi,
	output logic flash_select0_n,
	output logic flash_select1_n,
	output logic init_done_out,
	output logic init_done_oe,
	output logic [7:0] prog_rd_data,
	output logic rate_ok,
	output vibc_rgb_t disp_pixel,
	output logic disp_de,
	output logic disp_vsync,
	output logic glasses_sync,
	output logic format_ok
);
	vibc_boot_t state;
	vibc_boot_t next_state;
	logic [4:0] byte_idx;
	logic [7:0] tx_byte;
	logic go;
	logic fast;
	logic cmd_end;
	logic [31:0] init_cnt;
	logic [7:0] prog_mem [PROG_BYTES];
	logic eng_busy;
	logic eng_done;
	logic [7:0] eng_rx;

	// ---------------- flash boot, core clock ----------------
	vibc_spi_byte u_spi (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.start(go),
		.half(fast ? FAST_HALF : SLOW_HALF),
		.tx(tx_byte),
		.miso(flash_miso),
		.rx(eng_rx),
		.busy(eng_busy),
		.done(eng_done),
		.sclk(flash_sclk),
		.mosi(flash_mosi)
	);

	always_comb begin
		next_state = state;
		case (state)
			BOOT_IDLE: next_state = BOOT_WREN;
			BOOT_WREN: if (eng_done) next_state = BOOT_POLL;
			BOOT_POLL: begin
				// status is polled until the latch shows set
				if (eng_done && byte_idx == 5'h01 &&
					eng_rx[SR_LATCH_BIT]) begin
					next_state = BOOT_READ;
				end
			end
			BOOT_READ: begin
				if (eng_done && byte_idx == READ_LAST) begin
					next_state = BOOT_INIT;
				end
			end
			BOOT_INIT: if (init_cnt == 32'h0) next_state = BOOT_DONE;
			BOOT_DONE: next_state = BOOT_DONE;
			default: next_state = BOOT_IDLE;
		endcase
	end

	always_comb begin
		tx_byte = CMD_FILL;
		case (state)
			BOOT_WREN: tx_byte = CMD_WREN;
			BOOT_POLL: tx_byte = (byte_idx == 5'h00) ? CMD_RDSR : CMD_FILL;
			BOOT_READ: begin
				case (byte_idx)
					5'h00: tx_byte = CMD_FAST_READ;
					5'h01: tx_byte = BOOT_ADDR[23:16];
					5'h02: tx_byte = BOOT_ADDR[15:8];
					5'h03: tx_byte = BOOT_ADDR[7:0];
					default: tx_byte = CMD_FILL;
				endcase
			end
			default: tx_byte = CMD_FILL;
		endcase
	end

	assign cmd_end = eng_done && (state == BOOT_WREN ||
		(state == BOOT_POLL && byte_idx == 5'h01) ||
		(state == BOOT_READ && byte_idx == READ_LAST));

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= BOOT_IDLE;
			fast <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			if (state == BOOT_POLL && next_state == BOOT_READ) begin
				fast <= 1'b1;
			end
		end
	end

	// one byte at a time; go waits a cycle after done so chip select gaps
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			go <= 1'b0;
			byte_idx <= 5'h00;
			flash_select0_n <= 1'b1;
			flash_select1_n <= 1'b1;
		end else if (ce) begin
			go <= (state == BOOT_WREN || state == BOOT_POLL ||
				state == BOOT_READ) && !eng_busy && !go && !eng_done;
			flash_select1_n <= 1'b1;
			if (go) begin
				flash_select0_n <= 1'b0;
			end else if (cmd_end) begin
				flash_select0_n <= 1'b1;
			end
			if (cmd_end) begin
				byte_idx <= 5'h00;
			end else if (eng_done) begin
				byte_idx <= byte_idx + 5'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < PROG_BYTES; i++) begin
				prog_mem[i] <= 8'h00;
			end
			prog_rd_data <= 8'h00;
		end else if (ce) begin
			if (state == BOOT_READ && eng_done &&
				byte_idx >= 5'(READ_HDR)) begin
				prog_mem[4'(byte_idx - 5'(READ_HDR))] <= eng_rx;
			end
			prog_rd_data <= prog_mem[prog_rd_addr];
		end
	end

	// auto-init length stands in for the loaded routine's run time
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			init_cnt <= 32'h0;
		end else if (ce) begin
			if (state != BOOT_INIT) begin
				init_cnt <= INIT_CYCLES_P - 32'h1;
			end else if (init_cnt != 32'h0) begin
				init_cnt <= init_cnt - 32'h1;
			end
		end
	end

	// line is released until boot ends, then high, then low when done
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			init_done_oe <= 1'b0;
			init_done_out <= 1'b1;
		end else if (ce) begin
			init_done_oe <= next_state == BOOT_INIT ||
				next_state == BOOT_DONE;
			init_done_out <= next_state != BOOT_DONE;
		end
	end

	// ---------------- video front end, pixel clock ----------------
	logic pix_ce;
	logic done_pix;
	logic stereo_pix;
	logic vs_d;
	logic de_d;
	logic vs_rise;
	logic [11:0] hcnt;
	logic [11:0] line_w;
	logic [11:0] vcnt;
	logic armed;
	logic next_armed;
	logic eye_frame;
	logic next_eye;
	vibc_res_t next_res;
	vibc_frame_t frame_info;
	logic info_tgl;

	vibc_sync3 u_ce_sync (
		.clk(pix_clk),
		.resetn(resetn),
		.ce(1'b1),
		.d(ce),
		.q(pix_ce)
	);

	vibc_sync3 u_done_sync (
		.clk(pix_clk),
		.resetn(resetn),
		.ce(pix_ce),
		// a flop output crosses: a decoded state word could glitch
		.d(!init_done_out),
		.q(done_pix)
	);

	vibc_sync3 u_stereo_sync (
		.clk(pix_clk),
		.resetn(resetn),
		.ce(pix_ce),
		.d(stereo_mode),
		.q(stereo_pix)
	);

	assign vs_rise = vid_vsync && !vs_d;
	// a frame is taken only from a vsync seen after init, never mid-frame
	assign next_armed = vs_rise ? done_pix : (armed && done_pix);
	assign next_eye = vs_rise ? eye_select_in : eye_frame;

	always_comb begin
		// only landscape sizes are recognised
		if (line_w == QHD_W && vcnt == QHD_H) begin
			next_res = RES_QHD;
		end else if (line_w == FHD_W && vcnt == FHD_H) begin
			next_res = RES_FHD;
		end else begin
			next_res = RES_NONE;
		end
	end

	always_ff @(posedge pix_clk or negedge resetn) begin
		if (!resetn) begin
			vs_d <= 1'b0;
			de_d <= 1'b0;
			hcnt <= 12'h000;
			line_w <= 12'h000;
			vcnt <= 12'h000;
		end else if (pix_ce) begin
			vs_d <= vid_vsync;
			de_d <= vid_de;
			if (vid_de) begin
				hcnt <= hcnt + 12'h001;
			end else if (de_d) begin
				hcnt <= 12'h000;
				line_w <= hcnt;
				vcnt <= vcnt + 12'h001;
			end
			if (vs_rise) begin
				vcnt <= 12'h000;
			end
		end
	end

	always_ff @(posedge pix_clk or negedge resetn) begin
		if (!resetn) begin
			armed <= 1'b0;
			eye_frame <= 1'b0;
			frame_info <= '{res: RES_NONE, stereo: 1'b0};
			info_tgl <= 1'b0;
			format_ok <= 1'b0;
		end else if (pix_ce) begin
			armed <= next_armed;
			eye_frame <= next_eye;
			if (vs_rise) begin
				frame_info <= '{res: next_res, stereo: stereo_pix};
				info_tgl <= ~info_tgl;
				format_ok <= next_res != RES_NONE;
			end
		end
	end

	// pixels leave one cycle after arrival: no frame store, same rate
	always_ff @(posedge pix_clk or negedge resetn) begin
		if (!resetn) begin
			disp_pixel <= '0;
			disp_de <= 1'b0;
			disp_vsync <= 1'b0;
			glasses_sync <= 1'b0;
		end else if (pix_ce) begin
			disp_de <= next_armed && vid_de;
			disp_pixel <= (next_armed && vid_de) ?
				parallel_pixel_bus : '0;
			disp_vsync <= done_pix && vid_vsync;
			glasses_sync <= next_armed && next_eye &&
				(vs_rise ? stereo_pix : frame_info.stereo);
		end
	end

	// ---------------- frame rate check, core clock ----------------
	logic vt_sync;
	logic vt_d;
	logic have_prev;
	logic [31:0] per_cnt;
	logic [5:0] allowed;

	vibc_sync3 u_frame_sync (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.d(info_tgl),
		.q(vt_sync)
	);

	// frame_info changes only with the toggle, so it is settled when read
	always_comb begin
		case (frame_info.res)
			RES_QHD: allowed = frame_info.stereo ?
				STEREO_RATES : QHD_RATES;
			RES_FHD: allowed = frame_info.stereo ? 6'h00 : FHD_RATES;
			default: allowed = 6'h00;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vt_d <= 1'b0;
			have_prev <= 1'b0;
			per_cnt <= 32'h0;
			rate_ok <= 1'b0;
		end else if (ce) begin
			vt_d <= vt_sync;
			if (vt_sync != vt_d) begin
				rate_ok <= have_prev && rate_fits(per_cnt, allowed);
				have_prev <= 1'b1;
				per_cnt <= 32'h1;
			end else if (per_cnt != 32'hffffffff) begin
				per_cnt <= per_cnt + 32'h1;
			end
		end
	end

	// ---------------- checks ----------------
	irq_release_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(state == BOOT_WREN || state == BOOT_POLL || state == BOOT_READ)
		|-> !init_done_oe)
		else $error("init-done driven before boot finished");

	irq_high_a: assert property (
		@(posedge clk) disable iff (!resetn)
		state == BOOT_INIT |-> init_done_oe && init_done_out)
		else $error("init-done not driven high during auto-init");

	irq_low_a: assert property (
		@(posedge clk) disable iff (!resetn)
		$rose(state == BOOT_DONE) |-> init_done_oe && !init_done_out
		&& $past(state) == BOOT_INIT && $past(init_cnt) == 32'h0)
		else $error("init-done fell at the wrong moment");

	poll_exit_a: assert property (
		@(posedge clk) disable iff (!resetn)
		state == BOOT_READ && $past(state) == BOOT_POLL
		|-> $past(eng_rx[SR_LATCH_BIT]) && $past(eng_done))
		else $error("read began without write latch seen");

	slow_start_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(state == BOOT_WREN || state == BOOT_POLL) |-> !fast)
		else $error("fast flash clock before latch seen");

	boot_select_a: assert property (
		@(posedge clk) disable iff (!resetn)
		!flash_select0_n |-> flash_select1_n &&
		(state == BOOT_WREN || state == BOOT_POLL || state == BOOT_READ))
		else $error("flash selected outside boot");

	video_gate_a: assert property (
		@(posedge pix_clk) disable iff (!resetn)
		!done_pix |=> !disp_de && !disp_vsync)
		else $error("video passed before init complete");

	pixel_pass_a: assert property (
		@(posedge pix_clk) disable iff (!resetn)
		disp_de && $past(pix_ce) |->
		disp_pixel == $past(parallel_pixel_bus) && $past(vid_de))
		else $error("pixel not passed unchanged");

	eye_phase_a: assert property (
		@(posedge pix_clk) disable iff (!resetn)
		$rose(glasses_sync) |-> $past(vs_rise) && $past(eye_select_in))
		else $error("glasses sync rose off a left-eye vsync");
endmodule

/* File: verification/vibc_flash_model.sv */
// vibc_flash_model: serial boot flash seen on select zero.
// assumes mode 0 framing; answer bits move just after falling sclk.
`timescale 1ns/1ps
module vibc_flash_model
	import vibc_pkg::*;
(
	input wire logic sclk,
	input wire logic mosi,
	input wire logic cs_n,
	input wire logic [127:0] image,
	input wire logic [7:0] slow_polls,
	output logic miso,
	output logic [7:0] n_rdsr,
	output logic [7:0] n_cmds
);
	logic [7:0] cmd = 8'h00;
	logic [23:0] addr = 24'h000000;
	logic [7:0] base = 8'h00;
	logic [7:0] dbyte;
	logic armed = 1'b0;
	logic latch;
	logic [7:0] status;
	int bits = 0;
	// latch shows late by slow_polls reads so the poll loop is exercised
	assign latch = armed && 8'(n_rdsr - base) >= slow_polls;
	assign status = {6'h00, latch, armed & ~latch};
	initial begin
		miso = 1'b0;
		n_rdsr = 8'h00;
		n_cmds = 8'h00;
	end
	always @(negedge cs_n)
		bits = 0;
	// bits taken on rising sclk, msb first, 24 address bits
	always @(posedge sclk) begin
		if (!cs_n) begin
			if (bits < 8) cmd = {cmd[6:0], mosi};
			else if (bits < 32) addr = {addr[22:0], mosi};
			bits++;
		end
	end
	always @(posedge cs_n) begin
		if (bits >= 8) begin
			n_cmds = n_cmds + 8'h01;
			if (cmd == CMD_WREN) begin
				armed = 1'b1;
				base = n_rdsr;
			end
			if (cmd == CMD_RDSR) n_rdsr = n_rdsr + 8'h01;
		end
		// released line keeps no stable value
		miso = ~miso;
	end
	// untimed, so both serial clock rates are served
	always @(negedge sclk) begin
		if (!cs_n) begin
			#1;
			if (cmd == CMD_RDSR && bits >= 8)
				miso = status[7 - bits % 8];
			else if (cmd == CMD_FAST_READ && bits >= 40) begin
				// address auto-increments per byte
				dbyte = image[8 * ((addr + (bits - 40) / 8) % 16) +: 8];
				miso = dbyte[7 - bits % 8];
			end else
				miso = ~miso;
		end
	end
endmodule

/* File: verification/testbench.sv */
// testbench: boots the block from a flash model and streams small frames.
// assumes a pull-up on the init-done line, resolved here from oe and out.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	mismatches++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench;
	import vibc_pkg::*;
	localparam int INIT_P = 20;
	logic clk = 0, pix_clk = 0, resetn = 0, ce = 1;
	logic stereo_mode = 0, vsync = 0, de = 0, eye = 0, miso;
	vibc_rgb_t pix = '0, disp_pixel, p_pix;
	logic [3:0] rd_addr = 4'h0;
	logic sclk, mosi, sel0_n, sel1_n, id_out, id_oe, rate_ok, format_ok;
	logic disp_de, disp_vsync, glasses, live = 0, p_live = 0, p_de = 0;
	logic sel1_bad = 0, de_bad = 0;
	logic [7:0] rd_data, polls = 0, n_rdsr, n_cmds;
	logic [127:0] image;
	logic [15:0] lfsr_s = 16'h0006;
	int mismatches = 0, checks_done = 0;
	int hi_cnt = 0, first_hi = 0, last_hi = 0, init_cnt = 0;
	wire line = id_oe ? id_out : 1'b1;
	always #5 clk = ~clk;
	// offset keeps pixel edges clear of core edges
	initial begin
		#1.3;
		forever #3 pix_clk = ~pix_clk;
	end
	vibc_top #(.INIT_CYCLES_P(32'(INIT_P))) DUT (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.pix_clk(pix_clk),
		.stereo_mode(stereo_mode),
		.parallel_pixel_bus(pix),
		.vid_vsync(vsync),
		.vid_de(de),
		.eye_select_in(eye),
		.flash_miso(miso),
		.prog_rd_addr(rd_addr),
		.flash_sclk(sclk),
		.flash_mosi(mosi),
		.flash_select0_n(sel0_n),
		.flash_select1_n(sel1_n),
		.init_done_out(id_out),
		.init_done_oe(id_oe),
		.prog_rd_data(rd_data),
		.rate_ok(rate_ok),
		.disp_pixel(disp_pixel),
		.disp_de(disp_de),
		.disp_vsync(disp_vsync),
		.glasses_sync(glasses),
		.format_ok(format_ok)
	);
	vibc_flash_model flash_far (
		.sclk(sclk),
		.mosi(mosi),
		.cs_n(sel0_n),
		.image(image),
		.slow_polls(polls),
		.miso(miso),
		.n_rdsr(n_rdsr),
		.n_cmds(n_cmds)
	);
	function automatic logic [15:0] nxt(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	always @(negedge clk) begin
		if (sclk === 1'b1) hi_cnt++;
		else if (hi_cnt != 0) begin
			if (first_hi == 0) first_hi = hi_cnt;
			last_hi = hi_cnt;
			hi_cnt = 0;
		end
		if (id_oe === 1'b1 && id_out === 1'b1) init_cnt++;
		if (sel1_n !== 1'b1) sel1_bad = 1'b1;
	end
	always @(negedge pix_clk) begin
		if (line === 1'b1 && disp_de !== 1'b0) de_bad = 1'b1;
		if (p_live) begin
			`CHK("disp_de", p_de, disp_de)
			`CHK("disp_pixel", p_de ? p_pix : 24'h0, disp_pixel)
		end
		p_live = live;
		p_de = de;
		p_pix = pix;
	end
	task automatic pcyc(int n);
		repeat (n) @(posedge pix_clk);
	endtask
	task automatic boot(logic [7:0] np);
		logic [7:0] r0, c0, pre;
		r0 = n_rdsr;
		c0 = n_cmds;
		pre = c0;
		polls = np;
		@(posedge clk);
		resetn <= 1'b0;
		repeat (20) @(posedge clk);
		`CHK("line in reset", 1'b1, line)
		`CHK("sel0 in reset", 1'b1, sel0_n)
		first_hi = 0;
		init_cnt = 0;
		resetn <= 1'b1;
		for (int i = 0; i < 40000 && line !== 1'b0; i++) begin
			if (id_oe !== 1'b1) pre = n_cmds;
			@(posedge clk);
		end
		`CHK("done line", 1'b0, line)
		`CHK("init span", INIT_P, init_cnt)
		`CHK("boot first", 1'b1, 8'(pre - c0) >= np + 8'd2)
		`CHK("status reads", np + 8'd1, 8'(n_rdsr - r0))
		`CHK("commands", np + 8'd3, 8'(n_cmds - c0))
		`CHK("slow half", SLOW_HALF_CYC, first_hi)
		`CHK("fast half", FAST_HALF_CYC, last_hi)
		// clock enable low must hold the read port at its old value
		rd_addr <= 4'h0;
		repeat (2) @(posedge clk);
		ce <= 1'b0;
		rd_addr <= 4'h1;
		repeat (3) @(posedge clk);
		`CHK("ce hold", image[7:0], rd_data)
		ce <= 1'b1;
		for (int k = 0; k < 16; k++) begin
			rd_addr <= 4'(k);
			repeat (2) @(posedge clk);
			`CHK("prog byte", image[8 * k +: 8], rd_data)
		end
	endtask
	task automatic frame(int w, int h, logic e, logic st);
		vibc_rgb_t v;
		eye <= e; // level settles ahead of vsync
		pcyc(8);
		vsync <= 1'b1; // one eye per frame, opened by vsync
		pcyc(3);
		if (live) `CHK("glasses", e & st, glasses)
		`CHK("disp_vsync", live, disp_vsync)
		vsync <= 1'b0;
		for (int y = 0; y < h; y++) begin
			for (int x = 0; x < w; x++) begin
				lfsr_s = nxt(lfsr_s);
				v = {lfsr_s, lfsr_s[11:4]};
				// short source padded with zero low bits
				if (y == 0) v = v & 24'hf8fcf8;
				de <= 1'b1;
				pix <= v;
				pcyc(1);
			end
			de <= 1'b0;
			pix <= ~v;
			pcyc(3);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#900000;
		mismatches++;
		final_report();
	end
	initial begin
		for (int i = 0; i < 8; i++) begin
			lfsr_s = nxt(lfsr_s);
			image[16 * i +: 16] = lfsr_s;
		end
		image[15:0] = 16'h00ff;
		fork
			boot(8'd3);
			begin
				pcyc(300);
				frame(6, 4, 1'b1, 1'b0); // early video is dropped
			end
		join
		pcyc(10);
		live = 1'b1;
		frame(6, 4, 1'b0, 1'b0);
		stereo_mode <= 1'b1;
		pcyc(10);
		frame(6, 4, 1'b1, 1'b1); // eyes alternate
		frame(6, 4, 1'b0, 1'b1);
		frame(4, 6, 1'b1, 1'b1);
		pcyc(10);
		`CHK("format", 1'b0, format_ok)
		`CHK("rate", 1'b0, rate_ok)
		live = 1'b0;
		boot(8'd0);
		pcyc(10);
		live = 1'b1;
		frame(5, 3, 1'b1, 1'b1);
		`CHK("sel1 idle", 1'b0, sel1_bad)
		`CHK("early video", 1'b0, de_bad)
		final_report();
	end
endmodule
